// ---- src/console_map.vh ----
// Constants for the operator console panel logic
`ifndef CONSOLE_MAP_VH
`define CONSOLE_MAP_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define STALL_TIME_NS 2750
`define STALL_CYCLES ((`STALL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// Panel key positions in the key vector
// ----------------------------------------
`define KEY_LOAD 0
`define KEY_STORE 1
`define KEY_READ 2
`define KEY_START 3
`define KEY_CONT 4
`define KEY_STOP 5
`define KEY_COUNT 6

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_LAMPS 8'h08
`define REG_POINTER 8'h0c
`define REG_BUFFER 8'h10
`define REG_ADDRESS 8'h14

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_LOCK_BIT 0
`define STAT_RUN_BIT 0
`define STAT_STALL_BIT 1
`define STAT_ION_BIT 2
`define STAT_STOP_BIT 3
`define STAT_BUSY_BIT 4
`define LAMPS_MAJOR_LSB 0
`define LAMPS_INSTR_LSB 6
`define CTRL_RESET 1'b0
`define WORD_RESET 12'h000
`define FIELD_RESET 3'h0
`define MAJOR_LAMPS_OFF 6'h00
`define INSTR_LAMPS_OFF 8'h00
`define MAJOR_ONE 6'h01
`define INSTR_ONE 8'h01
`define MAJOR_CODE_LAST 3'h5
`define POINTER_STEP 12'h001

`endif

// ---- src/key_edge_sync.v ----
// Two-stage synchroniser and rising-edge detector for panel keys
`timescale 1ns/10ps
module key_edge_sync #(
   parameter N = 6
) (
   input wire clk, // Processor clock
   input wire rst_n, // Asynchronous reset, active low
   input wire [N-1:0] key_raw, // Raw key levels from the panel
   output wire [N-1:0] key_press // One-cycle pulse per press
);

   // ----------------------------------------
   // Per-key synchroniser and edge detector
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1)
      begin : g_key
         reg meta_reg;
         reg sync_reg;
         reg prev_reg;
         // First stage feeds only the second
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
               prev_reg <= 1'b0;
            end
            else
            begin
               meta_reg <= key_raw[i];
               sync_reg <= meta_reg;
               prev_reg <= sync_reg;
            end
         end
         // Rising edge gives one pulse
         assign key_press[i] = sync_reg & ~prev_reg;
      end
   endgenerate
endmodule

// ---- src/stall_timer.v ----
// Fixed-length stall interval timer
`timescale 1ns/10ps
module stall_timer #(
   parameter CYCLES = 344,
   parameter CNT_W = 12
) (
   input wire clk, // Processor clock
   input wire rst_n, // Asynchronous reset, active low
   input wire trigger, // Pulse starting a stall
   output reg active // Stall flip-flop state
);

   reg [CNT_W-1:0] count_reg;
   localparam integer LAST_INT = CYCLES - 1;
   localparam [CNT_W-1:0] LAST = LAST_INT[CNT_W-1:0];

   // ----------------------------------------
   // Count out the stall interval
   // ----------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active <= 1'b0;
         count_reg <= {CNT_W{1'b0}};
      end
      else if (trigger && !active)
      begin
         active <= 1'b1;
         count_reg <= {CNT_W{1'b0}};
      end
      else if (active)
      begin
         if (count_reg == LAST)
            active <= 1'b0;
         count_reg <= count_reg + 1'b1;
      end
   end
endmodule

// ---- src/operator_console_panel_logic.v ----
// Operator console panel logic: lamps, run control and manual load/store/readback
`timescale 1ns/10ps
`include "console_map.vh"
module operator_console_panel_logic #(
   parameter WORD_W = 12,
   parameter FIELD_W = 3,
   parameter STALL_CYCLES = `STALL_CYCLES
) (
   input wire clk, // Processor clock, 125 MHz
   input wire rst_n, // Asynchronous reset, active low
   // Panel keys and switches
   input wire load_addr_key, // Address-load key
   input wire store_word_key, // Store-word key
   input wire readback_key, // Readback key
   input wire start_key, // Start key
   input wire cont_key, // Continue key
   input wire stop_key, // Stop key
   input wire [WORD_W-1:0] panel_switch_word, // Switch word
   input wire [FIELD_W-1:0] inst_field_switch, // Instruction field switches
   input wire [FIELD_W-1:0] data_field_switch, // Data field switches
   input wire extension_fitted, // Memory extension present
   // Processor status
   input wire major_cycle_start, // Pulse: new major cycle begins
   input wire [2:0] major_cycle_code, // Cycle code 0..5
   input wire instr_start, // Pulse: new instruction begins
   input wire [2:0] instr_opcode, // Instruction class 0..7
   input wire instr_done, // Pulse: instruction finished
   input wire int_enable, // Interrupt enable flip-flop
   input wire io_strobe_needed, // Pulse: I/O transfer needs strobes
   input wire arith_shift_needed, // Pulse: arithmetic unit shift
   input wire pointer_load, // Processor loads pointer
   input wire [WORD_W-1:0] pointer_value, // Value for pointer
   input wire buffer_load, // Processor loads buffer
   input wire [WORD_W-1:0] buffer_value, // Value for buffer
   input wire address_load, // Processor loads address latch
   input wire [WORD_W-1:0] address_value, // Value for address latch
   // Core memory port
   output wire mem_req, // Request, held until ack
   output wire mem_write, // 1 write, 0 read
   output reg [WORD_W-1:0] mem_addr, // Memory address
   output reg [WORD_W-1:0] mem_wdata, // Write data
   input wire [WORD_W-1:0] mem_rdata, // Read data, valid with ack
   input wire mem_ack, // Pulse: access done
   // Lamps
   output reg [5:0] major_lamps, // Fetch, exec, defer, wc, ca, break
   output reg [7:0] instr_lamps, // And..opr one-hot
   output reg ion_lamp, // Interrupt-on lamp
   output wire stall_lamp, // Stall lamp
   output reg run_lamp, // Run lamp
   output wire timing_enable, // Timing generator enable
   output reg [WORD_W-1:0] next_instruction_pointer, // Pointer lamps
   output reg [WORD_W-1:0] memory_buffer_word, // Buffer lamps
   output reg [WORD_W-1:0] memory_address_latch, // Address lamps
   output reg [FIELD_W-1:0] inst_field_reg, // Instruction field lamps
   output reg [FIELD_W-1:0] data_field_reg, // Data field lamps
   // Register port
   input wire [7:0] reg_addr, // Byte address
   input wire [31:0] reg_wdata, // Write data
   input wire reg_wr, // Write strobe
   input wire reg_rd, // Read strobe
   output reg [31:0] reg_rdata // Read data, cycle after strobe
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_WRITE = 3'b010;
   localparam [2:0] ST_READ = 3'b100;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg stop_pending_reg;
   reg lock_reg;
   wire [`KEY_COUNT-1:0] key_raw;
   wire [`KEY_COUNT-1:0] key_press;
   wire idle;
   wire panel_ok;
   wire do_load;
   wire do_store;
   wire do_read;
   wire stall_trigger;
   wire [31:0] status_word;
   wire [31:0] lamps_word;

   // ----------------------------------------
   // Key conditioning
   // ----------------------------------------
   assign key_raw[`KEY_LOAD] = load_addr_key;
   assign key_raw[`KEY_STORE] = store_word_key;
   assign key_raw[`KEY_READ] = readback_key;
   assign key_raw[`KEY_START] = start_key;
   assign key_raw[`KEY_CONT] = cont_key;
   assign key_raw[`KEY_STOP] = stop_key;

   // Synchronise and edge-detect every key
   key_edge_sync #(
      .N(`KEY_COUNT)
   ) u_keys (
      .clk(clk),
      .rst_n(rst_n),
      .key_raw(key_raw),
      .key_press(key_press)
   );

   // Manual operations only while halted and unlocked
   assign idle = state_reg[0];
   assign panel_ok = idle & ~run_lamp & ~lock_reg;
   assign do_load = panel_ok & key_press[`KEY_LOAD];
   assign do_store = panel_ok & key_press[`KEY_STORE] & ~key_press[`KEY_LOAD];
   assign do_read = panel_ok & key_press[`KEY_READ] & ~key_press[`KEY_LOAD]
      & ~key_press[`KEY_STORE];

   // ----------------------------------------
   // Stall flip-flop
   // ----------------------------------------
   assign stall_trigger = io_strobe_needed | arith_shift_needed;

   // Timed stall interval
   stall_timer #(
      .CYCLES(STALL_CYCLES),
      .CNT_W(12)
   ) u_stall (
      .clk(clk),
      .rst_n(rst_n),
      .trigger(stall_trigger),
      .active(stall_lamp)
   );

   // ----------------------------------------
   // Run flip-flop and stop request
   // ----------------------------------------
   assign timing_enable = run_lamp;

   // Start/continue set run; stop waits for instruction end
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run_lamp <= 1'b0;
         stop_pending_reg <= 1'b0;
      end
      else if (run_lamp)
      begin
         if ((stop_pending_reg || key_press[`KEY_STOP]) && instr_done)
         begin
            run_lamp <= 1'b0;
            stop_pending_reg <= 1'b0;
         end
         else if (key_press[`KEY_STOP])
            stop_pending_reg <= 1'b1;
      end
      else if (idle && !lock_reg && (key_press[`KEY_START] || key_press[`KEY_CONT]))
      begin
         run_lamp <= 1'b1;
         stop_pending_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Status lamps
   // ----------------------------------------
   // Interrupt-on lamp follows enable flip-flop
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ion_lamp <= 1'b0;
      else
         ion_lamp <= int_enable;
   end

   // Major cycle lamp holds last cycle; cleared by panel operations
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         major_lamps <= `MAJOR_LAMPS_OFF;
      else if (do_load || do_store || do_read)
         major_lamps <= `MAJOR_LAMPS_OFF;
      else if (major_cycle_start && major_cycle_code <= `MAJOR_CODE_LAST)
         major_lamps <= `MAJOR_ONE << major_cycle_code;
   end

   // Instruction class lamp holds last instruction
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         instr_lamps <= `INSTR_LAMPS_OFF;
      else if (instr_start)
         instr_lamps <= `INSTR_ONE << instr_opcode;
   end

   // ----------------------------------------
   // Manual operation state machine
   // ----------------------------------------
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (do_store)
               state_next = ST_WRITE;
            else if (do_read)
               state_next = ST_READ;
         end
         ST_WRITE:
         begin
            if (mem_ack)
               state_next = ST_IDLE;
         end
         ST_READ:
         begin
            if (mem_ack)
               state_next = ST_IDLE;
         end
         default:
            state_next = ST_IDLE;
      endcase
   end

   // State register
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // Memory request while an access is outstanding
   assign mem_req = state_reg[1] | state_reg[2];
   assign mem_write = state_reg[1];

   // Memory address and data held for the access
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_addr <= `WORD_RESET;
         mem_wdata <= `WORD_RESET;
      end
      else if (do_store || do_read)
      begin
         mem_addr <= next_instruction_pointer;
         mem_wdata <= panel_switch_word;
      end
   end

   // ----------------------------------------
   // Pointer register
   // ----------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         next_instruction_pointer <= `WORD_RESET;
      else if (do_load)
         next_instruction_pointer <= panel_switch_word;
      else if (mem_req && mem_ack)
         next_instruction_pointer <= next_instruction_pointer + `POINTER_STEP;
      else if (pointer_load)
         next_instruction_pointer <= pointer_value;
   end

   // ----------------------------------------
   // Field registers
   // ----------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         inst_field_reg <= `FIELD_RESET;
         data_field_reg <= `FIELD_RESET;
      end
      else if (do_load && extension_fitted)
      begin
         inst_field_reg <= inst_field_switch;
         data_field_reg <= data_field_switch;
      end
   end

   // ----------------------------------------
   // Buffer and address latch
   // ----------------------------------------
   // Buffer takes switches on store, memory on readback
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         memory_buffer_word <= `WORD_RESET;
      else if (do_store)
         memory_buffer_word <= panel_switch_word;
      else if (state_reg[2] && mem_ack)
         memory_buffer_word <= mem_rdata;
      else if (buffer_load)
         memory_buffer_word <= buffer_value;
   end

   // Address latch keeps the address just stored or examined
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         memory_address_latch <= `WORD_RESET;
      else if (do_store || do_read)
         memory_address_latch <= next_instruction_pointer;
      else if (address_load)
         memory_address_latch <= address_value;
   end

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   // Control register: panel lock
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         lock_reg <= `CTRL_RESET;
      else if (reg_wr && reg_addr == `REG_CTRL)
         lock_reg <= reg_wdata[`CTRL_LOCK_BIT];
   end

   // Status and lamp words
   assign status_word = {27'h0000000, ~idle, stop_pending_reg, ion_lamp, stall_lamp, run_lamp};
   assign lamps_word = {18'h00000, instr_lamps, major_lamps};

   // Read data one cycle after the strobe; unmapped reads zero
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 32'h00000000;
      else if (!reg_rd)
         reg_rdata <= 32'h00000000;
      else if (reg_addr == `REG_CTRL)
         reg_rdata <= {31'h00000000, lock_reg};
      else if (reg_addr == `REG_STATUS)
         reg_rdata <= status_word;
      else if (reg_addr == `REG_LAMPS)
         reg_rdata <= lamps_word;
      else if (reg_addr == `REG_POINTER)
         reg_rdata <= {20'h00000, next_instruction_pointer};
      else if (reg_addr == `REG_BUFFER)
         reg_rdata <= {20'h00000, memory_buffer_word};
      else if (reg_addr == `REG_ADDRESS)
         reg_rdata <= {20'h00000, memory_address_latch};
      else
         reg_rdata <= 32'h00000000;
   end
endmodule

// ---- bench/core_mem_model.sv ----
// Core memory model answering console panel accesses
`timescale 1ns/10ps
module core_mem_model (
   input wire clk, // Clock
   input wire rst_n, // Reset, active low
   input wire mem_req, // Request level
   input wire mem_write, // Write select
   input wire [11:0] mem_addr, // Address
   input wire [11:0] mem_wdata, // Write data
   input wire [1:0] wait_cycles, // Answer delay
   output reg [11:0] mem_rdata, // Read data
   output reg mem_ack // Done pulse
);
   reg [11:0] core [0:4095];
   reg [1:0] cnt_reg;
   // Answer after the delay; read data toggles when not valid
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= 2'h0;
         mem_ack <= 1'b0;
         mem_rdata <= 12'hfff;
      end
      else
      begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack && cnt_reg != wait_cycles)
            cnt_reg <= cnt_reg + 2'h1;
         else if (mem_req && !mem_ack)
         begin
            cnt_reg <= 2'h0;
            mem_ack <= 1'b1;
            if (mem_write)
               core[mem_addr] <= mem_wdata;
            else
               mem_rdata <= core[mem_addr];
         end
      end
   end
endmodule

// ---- bench/console_chk.sv ----
// Port assertions for the console panel logic
`timescale 1ns/10ps
module console_chk #(
   parameter STALL_CYCLES = 344
) (
   input wire clk, // Clock
   input wire rst_n, // Reset, active low
   input wire major_cycle_start, // Cycle pulse
   input wire [2:0] major_cycle_code, // Cycle code
   input wire instr_start, // Instruction pulse
   input wire [2:0] instr_opcode, // Class code
   input wire instr_done, // End of instruction
   input wire int_enable, // Enable flip-flop
   input wire io_strobe_needed, // Stall trigger
   input wire arith_shift_needed, // Stall trigger
   input wire [11:0] panel_switch_word, // Switch word
   input wire mem_req, // Memory request
   input wire mem_write, // Write select
   input wire [11:0] mem_addr, // Address
   input wire [11:0] mem_wdata, // Write data
   input wire [11:0] mem_rdata, // Read data
   input wire mem_ack, // Done pulse
   input wire [5:0] major_lamps, // Cycle lamps
   input wire [7:0] instr_lamps, // Class lamps
   input wire ion_lamp, // Interrupt lamp
   input wire stall_lamp, // Stall lamp
   input wire run_lamp, // Run lamp
   input wire timing_enable, // Timing enable
   input wire [11:0] next_instruction_pointer, // Pointer
   input wire [11:0] memory_buffer_word, // Buffer
   input wire [11:0] memory_address_latch // Address latch
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   reg [15:0] st_cnt_reg;
   // Cycles of the current stall
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_cnt_reg <= 16'h0000;
      else
         st_cnt_reg <= stall_lamp ? st_cnt_reg + 16'h0001 : 16'h0000;
   end
   property p_major;
      major_cycle_start && major_cycle_code < 3'h6 |=> major_lamps == 6'h01 << $past(major_cycle_code);
   endproperty
   a_major: assert property (p_major) else $error("major lamp wrong");
   property p_instr;
      instr_start |=> instr_lamps == 8'h01 << $past(instr_opcode);
   endproperty
   a_instr: assert property (p_instr) else $error("class lamp wrong");
   property p_ion;
      ion_lamp == $past(int_enable);
   endproperty
   a_ion: assert property (p_ion) else $error("ion lamp wrong");
   property p_stall_go;
      (io_strobe_needed || arith_shift_needed) && !stall_lamp |=> stall_lamp;
   endproperty
   a_stall_go: assert property (p_stall_go) else $error("stall not set");
   property p_stall_len;
      $fell(stall_lamp) |-> st_cnt_reg == STALL_CYCLES;
   endproperty
   a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
   property p_timing;
      timing_enable == run_lamp;
   endproperty
   a_timing: assert property (p_timing) else $error("timing enable wrong");
   property p_hold;
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_write);
   endproperty
   a_hold: assert property (p_hold) else $error("request not held");
   property p_step;
      mem_req && mem_ack |=> !mem_req && next_instruction_pointer == $past(next_instruction_pointer) + 12'h001;
   endproperty
   a_step: assert property (p_step) else $error("pointer step wrong");
   property p_start;
      $rose(mem_req) |-> mem_addr == memory_address_latch && mem_addr == next_instruction_pointer
         && (!mem_write || mem_wdata == panel_switch_word && memory_buffer_word == panel_switch_word);
   endproperty
   a_start: assert property (p_start) else $error("access start wrong");
   property p_rdata;
      mem_req && mem_ack && !mem_write |=> memory_buffer_word == $past(mem_rdata);
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data lost");
   property p_stop;
      $fell(run_lamp) |-> $past(instr_done);
   endproperty
   a_stop: assert property (p_stop) else $error("run cleared early");
endmodule
bind operator_console_panel_logic console_chk #(.STALL_CYCLES(STALL_CYCLES)) chk (.*);

// ---- bench/tb_top.sv ----
// Self-checking testbench for the console panel logic
`timescale 1ns/10ps
`include "console_map.vh"
module tb_top;
   localparam STALL = 4;
   reg clk, rst_n, extension_fitted, major_cycle_start, instr_start, instr_done, int_enable;
   reg io_strobe_needed, arith_shift_needed, pointer_load, buffer_load, address_load, reg_wr, reg_rd;
   reg [2:0] major_cycle_code, instr_opcode, inst_field_switch, data_field_switch;
   reg [11:0] panel_switch_word, pointer_value, buffer_value, address_value, ea;
   reg [7:0] reg_addr;
   reg [31:0] reg_wdata;
   reg [5:0] keys;
   reg [1:0] mwait;
   wire load_addr_key = keys[0], store_word_key = keys[1], readback_key = keys[2];
   wire start_key = keys[3], cont_key = keys[4], stop_key = keys[5];
   wire mem_req, mem_write, mem_ack, ion_lamp, stall_lamp, run_lamp, timing_enable;
   wire [11:0] mem_addr, mem_wdata, mem_rdata, next_instruction_pointer, memory_buffer_word, memory_address_latch;
   wire [5:0] major_lamps;
   wire [7:0] instr_lamps;
   wire [2:0] inst_field_reg, data_field_reg;
   wire [31:0] reg_rdata;
   integer mismatches = 0;
   integer checks_done = 0;
   integer cycles = 0;
   integer i, n;
   operator_console_panel_logic #(.STALL_CYCLES(STALL)) uut (.*);
   core_mem_model mem (.*, .wait_cycles(mwait));
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         mismatches = mismatches + 1;
         end_sim;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp)
         begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
      begin
         @(posedge clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1;
         chk(reg_rdata, exp);
      end
   endtask
   // Hold a key for several cycles, then wait for any access
   task press(input integer k);
      begin
         @(posedge clk);
         keys[k] <= 1'b1;
         repeat (6) @(posedge clk);
         keys[k] <= 1'b0;
         n = 0;
         while (mem_req !== 1'b0 && n < 40)
         begin
            @(posedge clk);
            n = n + 1;
         end
         repeat (2) @(posedge clk);
         #1;
      end
   endtask
   task t_regs;
      begin
         rd(`REG_CTRL, 32'h0);
         rd(`REG_STATUS, 32'h0);
         rd(8'hfc, 32'h0);
         wr(`REG_POINTER, 32'hfff);
         rd(`REG_POINTER, 32'h0);
      end
   endtask
   task t_lamps;
      begin
         for (i = 0; i < 16; i = i + 1)
         begin
            @(posedge clk);
            major_cycle_start <= i < 8;
            instr_start <= i >= 8;
            major_cycle_code <= i;
            instr_opcode <= i - 8;
            @(posedge clk);
            {major_cycle_start, instr_start} <= 2'b00;
            #1;
            if (i < 8)
               chk(major_lamps, (i < 6) ? 32'h1 << i : 32'h20);
            else
               chk(instr_lamps, 32'h1 << (i - 8));
         end
         rd(`REG_LAMPS, 32'h2020);
         int_enable <= 1'b1;
         rd(`REG_STATUS, 32'h4);
         chk(ion_lamp, 1);
         int_enable <= 1'b0;
      end
   endtask
   task t_load;
      begin
         {pointer_value, buffer_value, address_value} <= {3{12'h3c1}};
         {pointer_load, buffer_load, address_load} <= 3'b111;
         @(posedge clk);
         {pointer_load, buffer_load, address_load} <= 3'b000;
         @(posedge clk);
         chk({next_instruction_pointer, memory_buffer_word}, {2{12'h3c1}});
         chk(memory_address_latch, 12'h3c1);
         panel_switch_word <= 12'ha5c;
         press(0);
         chk(next_instruction_pointer, 12'ha5c);
         rd(`REG_POINTER, 32'ha5c);
         chk(major_lamps, 0);
         chk({inst_field_reg, data_field_reg}, 6'h2a);
      end
   endtask
   task t_mem(input integer k);
      begin
         panel_switch_word <= 12'hffe;
         press(0);
         ea = 12'hffe;
         for (i = 0; i < 3; i = i + 1)
         begin
            panel_switch_word <= (k == 1) ? ~ea : ea;
            mwait <= mwait + 2'h1;
            press(k);
            chk(memory_address_latch, ea);
            chk(memory_buffer_word, {~ea});
            ea = ea + 12'h001;
            chk(next_instruction_pointer, ea);
         end
      end
   endtask
   task t_run;
      begin
         press(3);
         chk({run_lamp, timing_enable}, 2'b11);
         panel_switch_word <= 12'h055;
         press(0);
         chk(next_instruction_pointer, 12'h001);
         press(5);
         rd(`REG_STATUS, 32'h9);
         @(posedge clk);
         instr_done <= 1'b1;
         @(posedge clk);
         instr_done <= 1'b0;
         #1;
         chk({run_lamp, timing_enable}, 2'b00);
         press(4);
         chk(run_lamp, 1);
         press(5);
         instr_done <= 1'b1;
         @(posedge clk);
         instr_done <= 1'b0;
         #1;
         chk(run_lamp, 0);
      end
   endtask
   task t_stall;
      begin
         for (i = 0; i < 2; i = i + 1)
         begin
            @(posedge clk);
            io_strobe_needed <= i == 0;
            arith_shift_needed <= i == 1;
            @(posedge clk);
            {io_strobe_needed, arith_shift_needed} <= 2'b11;
            #1;
            n = 0;
            while (stall_lamp === 1'b1 && n < 50)
            begin
               @(posedge clk);
               {io_strobe_needed, arith_shift_needed} <= 2'b00;
               #1;
               n = n + 1;
            end
            chk(n, STALL);
         end
      end
   endtask
   task t_lock;
      begin
         wr(`REG_CTRL, 32'h1);
         rd(`REG_CTRL, 32'h1);
         panel_switch_word <= 12'h777;
         press(0);
         chk(next_instruction_pointer, 12'h001);
         wr(`REG_CTRL, 32'h0);
         extension_fitted <= 1'b0;
         {inst_field_switch, data_field_switch} <= 6'h3f;
         press(0);
         chk(next_instruction_pointer, 12'h777);
         chk({inst_field_reg, data_field_reg}, 6'h2a);
      end
   endtask
   // Main sequence
   initial
   begin
      {rst_n, major_cycle_start, instr_start, instr_done, int_enable, io_strobe_needed} = 0;
      {arith_shift_needed, pointer_load, buffer_load, address_load, reg_wr, reg_rd, keys} = 0;
      {major_cycle_code, instr_opcode, panel_switch_word, reg_addr, reg_wdata, mwait} = 0;
      {pointer_value, buffer_value, address_value} = 0;
      {extension_fitted, inst_field_switch, data_field_switch} = 7'h6a;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_lamps;
      t_load;
      t_mem(1);
      t_mem(2);
      t_run;
      t_stall;
      t_lock;
      end_sim;
   end
endmodule
